/* logic/peripheral_irq_enable_flag_bank.sv */
// Peripheral interrupt enable and request-flag bank with AXI4-Lite register access
//
// Functional notes
// - External pin enable gates external pin request
// - External input chosen by pin select register
// - Groups one and two need peripheral enable
// - Group zero sources bypass peripheral enable
// - Group one enables: read/write, reset zero
// - Group two enables bits 7..5; rest zero
// - Group zero flags at bits 5, 4, 0
// - Timer0 flag sticky until software writes zero
// - Pin change flag is OR of ports
// - External flag set on edge, sticky
// - Flags set regardless of any enable
// - Group one flag layout, reset zero
// - Capture/compare 1 flag set by its event
// - Hardware-set flags cleared by software write
// - Receive flag mirrors receive buffer not empty
// - Transmit flag mirrors transmit buffer empty
// - Global enable cleared blocks every request
// - Edge polarity picks rising or falling edge
//
// Chosen here: the AXI4-Lite slave port.
`default_nettype none
module peripheral_irq_enable_flag_bank
  import irq_bank_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire axi_req_type axi_req,
  output var axi_rsp_type axi_rsp,
  input wire periph_events_type periph_events,
  input wire logic [EXT_PIN_COUNT-1:0] ext_pins,
  output var logic irq_request
);

  // Pin synchroniser, edge detector and request register
  logic [EXT_PIN_COUNT-1:0] pin_meta_q, pin_meta_d;
  logic [EXT_PIN_COUNT-1:0] pin_sync_q, pin_sync_d;
  logic sel_prev_q, sel_prev_d;
  logic irq_q, irq_d;
  logic sel_now;
  logic ext_edge;

  // Register file
  logic [7:0] ctrl_q, ctrl_d;
  logic [7:0] en0_q, en0_d;
  logic [7:0] en1_q, en1_d;
  logic [7:0] en2_q, en2_d;
  logic [SEL_W-1:0] sel_q, sel_d;
  logic [7:0] f0_q, f0_d;
  logic [7:0] f1_q, f1_d;
  logic [7:0] f2_q, f2_d;
  logic [7:0] f0_view, f1_view;
  logic pin_change;

  // Bus state
  axi_rsp_type rsp_q, rsp_d;
  logic aw_hold_q, aw_hold_d;
  logic w_hold_q, w_hold_d;
  logic [ADDR_W-1:0] aw_addr_q, aw_addr_d;
  logic [7:0] w_byte_q, w_byte_d;
  logic w_lane_q, w_lane_d;
  logic do_write, wr_ok, wen;
  logic [10:0] wr_idx, rd_idx;
  logic [7:0] wr_byte, rd_byte;
  logic rd_ok;
  logic [7:0] ev0, ev1, ev2;

  function automatic logic idx_mapped(input logic [10:0] idx);
    return idx inside {IDX_CONTROL, IDX_FLAGS0, IDX_FLAGS1, IDX_FLAGS2,
                       IDX_ENABLE0, IDX_ENABLE1, IDX_ENABLE2, IDX_PIN_SELECT};
  endfunction

  // Live read views of the group zero and group one flag registers
  always_comb begin
    pin_change = |{periph_events.port_a_change_flags, periph_events.port_c_change_flags};
    f0_view = f0_q;
    f0_view[G0_PIN_CHANGE_BIT] = pin_change;
    f1_view = f1_q;
    f1_view[G1_SERIAL_RX_BIT] = periph_events.serial_rx_not_empty;
    f1_view[G1_SERIAL_TX_BIT] = periph_events.serial_tx_empty;
  end

  // Edge detection on the selected pin and request qualification
  always_comb begin
    pin_meta_d = ext_pins;
    pin_sync_d = pin_meta_q;
    sel_now = pin_sync_q[sel_q];
    sel_prev_d = sel_now;
    if (ctrl_q[CTRL_EDGE_BIT]) begin
      ext_edge = sel_now && !sel_prev_q;
    end else begin
      ext_edge = !sel_now && sel_prev_q;
    end
    irq_d = ctrl_q[CTRL_GLOBAL_BIT] &&
            ((|(f0_view & en0_q)) ||
             (ctrl_q[CTRL_PERIPH_BIT] && ((|(f1_view & en1_q)) || (|(f2_q & en2_q)))));
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta_q <= '0;
      pin_sync_q <= '0;
      sel_prev_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      pin_meta_q <= pin_meta_d;
      pin_sync_q <= pin_sync_d;
      sel_prev_q <= sel_prev_d;
      irq_q <= irq_d;
    end
  end

  // Bus slave and register updates
  always_comb begin
    rsp_d = rsp_q;
    aw_hold_d = aw_hold_q;
    w_hold_d = w_hold_q;
    aw_addr_d = aw_addr_q;
    w_byte_d = w_byte_q;
    w_lane_d = w_lane_q;
    ctrl_d = ctrl_q;
    en0_d = en0_q;
    en1_d = en1_q;
    en2_d = en2_q;
    sel_d = sel_q;
    do_write = aw_hold_q && w_hold_q && !rsp_q.bvalid;
    wr_idx = aw_addr_q[ADDR_W-1:2];
    wr_ok = (aw_addr_q[1:0] == 2'h0) && idx_mapped(wr_idx);
    wen = do_write && wr_ok && w_lane_q;
    wr_byte = w_byte_q;
    if (axi_req.awvalid && rsp_q.awready) begin
      aw_hold_d = 1'b1;
      aw_addr_d = axi_req.awaddr;
    end
    if (axi_req.wvalid && rsp_q.wready) begin
      w_hold_d = 1'b1;
      w_byte_d = axi_req.wdata[7:0];
      w_lane_d = axi_req.wstrb[0];
    end
    if (do_write) begin
      aw_hold_d = 1'b0;
      w_hold_d = 1'b0;
      rsp_d.bvalid = 1'b1;
      rsp_d.bresp = wr_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (rsp_q.bvalid && axi_req.bready) begin
      rsp_d.bvalid = 1'b0;
    end
    rsp_d.awready = !aw_hold_d && !rsp_d.bvalid;
    rsp_d.wready = !w_hold_d && !rsp_d.bvalid;
    if (wen) begin
      case (wr_idx)
        IDX_CONTROL: ctrl_d = wr_byte & CONTROL_MASK;
        IDX_ENABLE0: en0_d = wr_byte & ENABLE0_MASK;
        IDX_ENABLE1: en1_d = wr_byte;
        IDX_ENABLE2: en2_d = wr_byte & GROUP2_MASK;
        IDX_PIN_SELECT: sel_d = wr_byte[SEL_W-1:0];
        default: ;
      endcase
    end
    // Hardware set wins over a simultaneous software write
    ev0 = 8'h00;
    ev0[G0_TIMER0_BIT] = periph_events.timer0_overflow;
    ev0[G0_EXT_BIT] = ext_edge;
    ev1 = {periph_events.capcmp1_event, periph_events.timer2_event,
           periph_events.timer1_event, 2'b00, periph_events.bus_collision_event,
           periph_events.sync_serial_event, periph_events.adc_event};
    ev2 = {periph_events.capcmp2_event, periph_events.memop_done_event,
           periph_events.timer1_gate_event, 5'b00000};
    f0_d = (ev0 | ((wen && wr_idx == IDX_FLAGS0) ? wr_byte : f0_q)) & FLAGS0_STORE_MASK;
    f1_d = (ev1 | ((wen && wr_idx == IDX_FLAGS1) ? wr_byte : f1_q)) & FLAGS1_STORE_MASK;
    f2_d = (ev2 | ((wen && wr_idx == IDX_FLAGS2) ? wr_byte : f2_q)) & GROUP2_MASK;
    rd_idx = axi_req.araddr[ADDR_W-1:2];
    rd_ok = (axi_req.araddr[1:0] == 2'h0) && idx_mapped(rd_idx);
    case (rd_idx)
      IDX_CONTROL: rd_byte = ctrl_q;
      IDX_FLAGS0: rd_byte = f0_view;
      IDX_FLAGS1: rd_byte = f1_view;
      IDX_FLAGS2: rd_byte = f2_q;
      IDX_ENABLE0: rd_byte = en0_q;
      IDX_ENABLE1: rd_byte = en1_q;
      IDX_ENABLE2: rd_byte = en2_q;
      IDX_PIN_SELECT: rd_byte = {5'b00000, sel_q};
      default: rd_byte = 8'h00;
    endcase
    if (axi_req.arvalid && rsp_q.arready) begin
      rsp_d.arready = 1'b0;
      rsp_d.rvalid = 1'b1;
      rsp_d.rdata = {24'h000000, rd_ok ? rd_byte : 8'h00};
      rsp_d.rresp = rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (rsp_q.rvalid && axi_req.rready) begin
      rsp_d.rvalid = 1'b0;
      rsp_d.arready = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rsp_q <= '{awready: 1'b1, wready: 1'b1, bvalid: 1'b0, bresp: RESP_OKAY,
                 arready: 1'b1, rvalid: 1'b0, rdata: 32'h00000000, rresp: RESP_OKAY};
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      aw_addr_q <= '0;
      w_byte_q <= 8'h00;
      w_lane_q <= 1'b0;
      ctrl_q <= CONTROL_RESET;
      en0_q <= REG_RESET;
      en1_q <= REG_RESET;
      en2_q <= REG_RESET;
      sel_q <= SELECT_RESET;
      f0_q <= REG_RESET;
      f1_q <= REG_RESET;
      f2_q <= REG_RESET;
    end else begin
      rsp_q <= rsp_d;
      aw_hold_q <= aw_hold_d;
      w_hold_q <= w_hold_d;
      aw_addr_q <= aw_addr_d;
      w_byte_q <= w_byte_d;
      w_lane_q <= w_lane_d;
      ctrl_q <= ctrl_d;
      en0_q <= en0_d;
      en1_q <= en1_d;
      en2_q <= en2_d;
      sel_q <= sel_d;
      f0_q <= f0_d;
      f1_q <= f1_d;
      f2_q <= f2_d;
    end
  end

  assign axi_rsp = rsp_q;
  assign irq_request = irq_q;

  // Checks
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  sequence rise_s;
    ctrl_q[CTRL_EDGE_BIT] && pin_sync_q[sel_q] && !sel_prev_q;
  endsequence

  sequence fall_s;
    !ctrl_q[CTRL_EDGE_BIT] && !pin_sync_q[sel_q] && sel_prev_q;
  endsequence

  sequence flags0_read_s;
    axi_req.arvalid && rsp_q.arready && axi_req.araddr == {IDX_FLAGS0, 2'b00};
  endsequence

  sequence flags1_read_s;
    axi_req.arvalid && rsp_q.arready && axi_req.araddr == {IDX_FLAGS1, 2'b00};
  endsequence

  a_ext_en_request: assert property (
    (ctrl_q[CTRL_GLOBAL_BIT] && f0_q[G0_EXT_BIT] && en0_q[G0_EXT_BIT]) |=> irq_request)
    else $error("enabled external flag gave no request");
  a_ext_rise_set: assert property (rise_s |=> f0_q[G0_EXT_BIT])
    else $error("rising edge on selected pin did not set flag");
  a_ext_fall_set: assert property (fall_s |=> f0_q[G0_EXT_BIT])
    else $error("falling edge on selected pin did not set flag");
  a_periph_gate: assert property (
    (!ctrl_q[CTRL_PERIPH_BIT] && ((f0_view & en0_q) == 8'h00)) |=> !irq_request)
    else $error("group one or two request passed without peripheral enable");
  a_group0_direct: assert property (
    (ctrl_q[CTRL_GLOBAL_BIT] && !ctrl_q[CTRL_PERIPH_BIT] && f0_q[G0_TIMER0_BIT] &&
     en0_q[G0_TIMER0_BIT]) |=> irq_request)
    else $error("timer0 request blocked by peripheral enable");
  a_enable1_write: assert property (
    (wen && wr_idx == IDX_ENABLE1) |=> en1_q == $past(wr_byte))
    else $error("group one enable write lost");
  a_enable2_reserved: assert property (en2_q[4:0] == 5'h00)
    else $error("unimplemented group two enable bits set");
  a_timer0_sticky: assert property (
    (f0_q[G0_TIMER0_BIT] && !(wen && wr_idx == IDX_FLAGS0 && !wr_byte[G0_TIMER0_BIT]))
    |=> f0_q[G0_TIMER0_BIT])
    else $error("timer0 flag dropped without software clear");
  a_pin_change_read: assert property (
    flags0_read_s |=> rsp_q.rvalid && rsp_q.rdata[G0_PIN_CHANGE_BIT] == $past(pin_change))
    else $error("pin change flag read wrong");
  a_rx_tx_read: assert property (
    flags1_read_s |=> rsp_q.rdata[G1_SERIAL_RX_BIT] == $past(periph_events.serial_rx_not_empty)
                      && rsp_q.rdata[G1_SERIAL_TX_BIT] == $past(periph_events.serial_tx_empty))
    else $error("serial buffer flags read wrong");
  a_flag_no_enable: assert property (
    (periph_events.adc_event && !en1_q[G1_ADC_BIT]) |=> f1_q[G1_ADC_BIT])
    else $error("adc flag not set while disabled");
  a_capcmp1_set: assert property (periph_events.capcmp1_event |=> f1_q[G1_CAPCMP1_BIT])
    else $error("capture compare flag not set");
  a_bus_coll_sticky: assert property (
    (f1_q[G1_BUS_COLLISION_BIT] && !(wen && wr_idx == IDX_FLAGS1)) |=> f1_q[G1_BUS_COLLISION_BIT])
    else $error("bus collision flag dropped by itself");
  a_global_block: assert property (!ctrl_q[CTRL_GLOBAL_BIT] |=> !irq_request)
    else $error("request raised with global enable clear");
  a_single_request: assert property (
    (ctrl_q[CTRL_GLOBAL_BIT] && ctrl_q[CTRL_PERIPH_BIT] && en1_q[G1_ADC_BIT] &&
     periph_events.adc_event && !wen) ##1 !wen |=> irq_request)
    else $error("qualified adc event gave no request in two cycles");
  a_set_wins: assert property (
    (periph_events.timer0_overflow && wen && wr_idx == IDX_FLAGS0) |=> f0_q[G0_TIMER0_BIT])
    else $error("simultaneous clear lost timer0 event");

endmodule // peripheral_irq_enable_flag_bank
`default_nettype wire

/* pkg/irq_bank_pkg.sv */
// Constants and carrier types for the peripheral interrupt enable and flag bank
`default_nettype none
package irq_bank_pkg;
  localparam int ADDR_W = 13;
  localparam int DATA_W = 32;
  localparam int EXT_PIN_COUNT = 8;
  localparam int SEL_W = 3;
  localparam int PORT_FLAG_W = 8;
  // Register indices; byte address is four times the index
  localparam logic [10:0] IDX_CONTROL = 11'h00B;
  localparam logic [10:0] IDX_FLAGS0 = 11'h70C;
  localparam logic [10:0] IDX_FLAGS1 = 11'h70D;
  localparam logic [10:0] IDX_FLAGS2 = 11'h70E;
  localparam logic [10:0] IDX_ENABLE0 = 11'h716;
  localparam logic [10:0] IDX_ENABLE1 = 11'h717;
  localparam logic [10:0] IDX_ENABLE2 = 11'h718;
  localparam logic [10:0] IDX_PIN_SELECT = 11'h719;
  // Control register fields
  localparam int CTRL_GLOBAL_BIT = 7;
  localparam int CTRL_PERIPH_BIT = 6;
  localparam int CTRL_EDGE_BIT = 0;
  localparam logic [7:0] CONTROL_MASK = 8'hC1;
  localparam logic [7:0] CONTROL_RESET = 8'h01;
  // Group 0 fields, shared by flags and enables
  localparam int G0_TIMER0_BIT = 5;
  localparam int G0_PIN_CHANGE_BIT = 4;
  localparam int G0_EXT_BIT = 0;
  localparam logic [7:0] ENABLE0_MASK = 8'h31;
  localparam logic [7:0] FLAGS0_STORE_MASK = 8'h21;
  // Group 1 fields
  localparam int G1_CAPCMP1_BIT = 7;
  localparam int G1_SERIAL_RX_BIT = 4;
  localparam int G1_SERIAL_TX_BIT = 3;
  localparam int G1_BUS_COLLISION_BIT = 2;
  localparam int G1_ADC_BIT = 0;
  localparam logic [7:0] FLAGS1_STORE_MASK = 8'hE7;
  // Group 2 fields, reset values and bus response codes
  localparam logic [7:0] GROUP2_MASK = 8'hE0;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [SEL_W-1:0] SELECT_RESET = 3'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic timer0_overflow;
    logic capcmp1_event;
    logic timer2_event;
    logic timer1_event;
    logic bus_collision_event;
    logic sync_serial_event;
    logic adc_event;
    logic capcmp2_event;
    logic memop_done_event;
    logic timer1_gate_event;
    logic serial_rx_not_empty;
    logic serial_tx_empty;
    logic [PORT_FLAG_W-1:0] port_a_change_flags;
    logic [PORT_FLAG_W-1:0] port_c_change_flags;
  } periph_events_type;

  typedef struct packed {
    logic [ADDR_W-1:0] awaddr;
    logic awvalid;
    logic [DATA_W-1:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [ADDR_W-1:0] araddr;
    logic arvalid;
    logic rready;
  } axi_req_type;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [DATA_W-1:0] rdata;
    logic [1:0] rresp;
  } axi_rsp_type;
endpackage
`default_nettype wire

/* testbench/periph_event_model.sv */
// Behavioural model of the peripherals and pins that raise events
`default_nettype none
module periph_event_model
  import irq_bank_pkg::*;
(
  input wire logic sys_clk,
  output var periph_events_type periph_events,
  output var logic [EXT_PIN_COUNT-1:0] ext_pins
);
  timeunit 1ns;
  timeprecision 1ns;
  int rx_count = 0;
  initial begin
    periph_events = '0;
    ext_pins = '0;
  end
  // One-cycle event pulse, n counts from the timer0 source in field order
  task automatic pulse(input int n);
    @(posedge sys_clk);
    drive(n, 1'b1);
    @(posedge sys_clk);
    drive(n, 1'b0);
  endtask
  task automatic drive(input int n, input logic v);
    case (n)
      0: periph_events.timer0_overflow <= v;
      1: periph_events.capcmp1_event <= v;
      2: periph_events.timer2_event <= v;
      3: periph_events.timer1_event <= v;
      4: periph_events.bus_collision_event <= v;
      5: periph_events.sync_serial_event <= v;
      6: periph_events.adc_event <= v;
      7: periph_events.capcmp2_event <= v;
      8: periph_events.memop_done_event <= v;
      9: periph_events.timer1_gate_event <= v;
      default: ;
    endcase
  endtask
  task automatic ports(input logic [7:0] a, input logic [7:0] c);
    @(posedge sys_clk);
    periph_events.port_a_change_flags <= a;
    periph_events.port_c_change_flags <= c;
  endtask
  task automatic pins(input logic [EXT_PIN_COUNT-1:0] p);
    @(posedge sys_clk);
    ext_pins <= p;
  endtask
  task automatic rx_push;
    @(posedge sys_clk);
    rx_count++;
    periph_events.serial_rx_not_empty <= 1'b1;
  endtask
  // Reading the receive data empties one byte
  task automatic rx_read;
    @(posedge sys_clk);
    rx_count--;
    periph_events.serial_rx_not_empty <= (rx_count != 0);
  endtask
  // Loading transmit data makes the buffer not empty
  task automatic tx_set(input logic e);
    @(posedge sys_clk);
    periph_events.serial_tx_empty <= e;
  endtask
endmodule // periph_event_model
`default_nettype wire

/* testbench/test_peripheral_irq_enable_flag_bank.sv */
// Self-checking bench of the interrupt enable and flag bank
`default_nettype none
module test_peripheral_irq_enable_flag_bank
  import irq_bank_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [ADDR_W-1:0] CTL = {IDX_CONTROL, 2'b00};
  localparam logic [ADDR_W-1:0] F0 = {IDX_FLAGS0, 2'b00};
  localparam logic [ADDR_W-1:0] F1 = {IDX_FLAGS1, 2'b00};
  localparam logic [ADDR_W-1:0] F2 = {IDX_FLAGS2, 2'b00};
  localparam logic [ADDR_W-1:0] E0 = {IDX_ENABLE0, 2'b00};
  localparam logic [ADDR_W-1:0] E1 = {IDX_ENABLE1, 2'b00};
  localparam logic [ADDR_W-1:0] E2 = {IDX_ENABLE2, 2'b00};
  localparam logic [ADDR_W-1:0] SEL = {IDX_PIN_SELECT, 2'b00};
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  axi_req_type req = '0;
  logic [3:0] strb = 4'hF;
  axi_rsp_type rsp;
  periph_events_type ev;
  logic [EXT_PIN_COUNT-1:0] pins;
  logic irq;
  int num_errors = 0;
  int checks_done = 0;
  int cyc = 0;
  peripheral_irq_enable_flag_bank dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .axi_req(req),
    .axi_rsp(rsp), .periph_events(ev), .ext_pins(pins), .irq_request(irq));
  periph_event_model pm (.sys_clk(sys_clk), .periph_events(ev), .ext_pins(pins));
  initial begin
    forever #10 sys_clk = ~sys_clk;
  end
  task automatic end_of_test;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 5000) begin
      num_errors++;
      $display("[FAIL] %0t timeout", $time);
      end_of_test;
    end
  end
  task automatic note(input logic ok, input string s);
    checks_done++;
    if (!ok) begin
      num_errors++;
      $display("[FAIL] %0t %s", $time, s);
    end
  endtask
  task automatic chk_data(input logic [31:0] g, input logic [31:0] e);
    note(g === e, $sformatf("data %h exp %h", g, e));
  endtask
  task automatic chk_resp(input logic [1:0] g, input logic [1:0] e);
    note(g === e, $sformatf("resp %h exp %h", g, e));
  endtask
  task automatic chk_irq(input logic g, input logic e);
    note(g === e, $sformatf("irq %b exp %b", g, e));
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d, output logic [1:0] r);
    logic aw_p;
    logic w_p;
    @(posedge sys_clk);
    req.awaddr <= a;
    req.awvalid <= 1'b1;
    req.wdata <= {24'h000000, d};
    req.wstrb <= strb;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    aw_p = 1'b1;
    w_p = 1'b1;
    while (aw_p | w_p) begin
      @(negedge sys_clk);
      aw_p = aw_p & ~rsp.awready;
      w_p = w_p & ~rsp.wready;
      @(posedge sys_clk);
      req.awvalid <= aw_p;
      req.wvalid <= w_p;
    end
    do @(negedge sys_clk); while (rsp.bvalid !== 1'b1);
    r = rsp.bresp;
    @(posedge sys_clk);
    req.bready <= 1'b0;
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge sys_clk);
    req.araddr <= a;
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    do @(negedge sys_clk); while (rsp.arready !== 1'b1);
    @(posedge sys_clk);
    req.arvalid <= 1'b0;
    do @(negedge sys_clk); while (rsp.rvalid !== 1'b1);
    d = rsp.rdata;
    r = rsp.rresp;
    @(posedge sys_clk);
    req.rready <= 1'b0;
  endtask
  task automatic wchk(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    logic [1:0] r;
    wr(a, d, r);
    chk_resp(r, RESP_OKAY);
  endtask
  task automatic rchk(input logic [ADDR_W-1:0] a, input logic [7:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk_data(d, {24'h000000, e});
    chk_resp(r, RESP_OKAY);
  endtask
  task automatic settle;
    repeat (6) @(negedge sys_clk);
  endtask
  task automatic irq_is(input logic e);
    settle;
    chk_irq(irq, e);
  endtask
  task automatic t_reset;
    logic [ADDR_W-1:0] a [8];
    a = '{CTL, F0, F1, F2, E0, E1, E2, SEL};
    chk_irq(irq, 1'b0);
    foreach (a[k]) rchk(a[k], (k == 0) ? 8'h01 : 8'h00);
    $display("t_reset done");
  endtask
  task automatic t_regs;
    logic [ADDR_W-1:0] a [5];
    logic [7:0] e [5];
    logic [31:0] d;
    logic [1:0] r;
    a = '{E0, E1, E2, SEL, CTL};
    e = '{8'h31, 8'hFF, 8'hE0, 8'h07, 8'hC1};
    foreach (a[k]) begin
      wchk(a[k], 8'hFF);
      rchk(a[k], e[k]);
      wchk(a[k], 8'h00);
    end
    wchk(CTL, 8'h01);
    // Low byte lane off: answered OKAY, nothing stored
    strb = 4'hE;
    wchk(E1, 8'hFF);
    strb = 4'hF;
    rchk(E1, 8'h00);
    wr(13'h0100, 8'hFF, r);
    chk_resp(r, RESP_SLVERR);
    rd(13'h0100, d, r);
    chk_resp(r, RESP_SLVERR);
    chk_data(d, 32'h00000000);
    wr(F0 + 13'h0001, 8'hFF, r);
    chk_resp(r, RESP_SLVERR);
    $display("t_regs done");
  endtask
  task automatic t_flags;
    for (int n = 0; n < 10; n++) pm.pulse(n);
    irq_is(1'b0);
    rchk(F0, 8'h20);
    rchk(F1, 8'hE7);
    rchk(F2, 8'hE0);
    wchk(F0, 8'h00);
    wchk(F1, 8'h00);
    wchk(F2, 8'h00);
    rchk(F0, 8'h00);
    rchk(F1, 8'h00);
    rchk(F2, 8'h00);
    // Clear lands on the same edge as the adc event
    fork
      wchk(F1, 8'h00);
      begin
        @(posedge sys_clk);
        pm.pulse(6);
      end
    join
    rchk(F1, 8'h01);
    wchk(F1, 8'h00);
    fork
      wchk(F0, 8'h00);
      begin
        @(posedge sys_clk);
        pm.pulse(0);
      end
    join
    rchk(F0, 8'h20);
    wchk(F0, 8'h00);
    $display("t_flags done");
  endtask
  task automatic t_live;
    pm.ports(8'h04, 8'h00);
    rchk(F0, 8'h10);
    wchk(F0, 8'h00);
    rchk(F0, 8'h10);
    pm.ports(8'h00, 8'h80);
    rchk(F0, 8'h10);
    pm.ports(8'h00, 8'h00);
    rchk(F0, 8'h00);
    pm.rx_push;
    pm.rx_push;
    rchk(F1, 8'h10);
    pm.rx_read;
    rchk(F1, 8'h10);
    pm.rx_read;
    rchk(F1, 8'h00);
    pm.tx_set(1'b1);
    rchk(F1, 8'h08);
    pm.tx_set(1'b0);
    rchk(F1, 8'h00);
    $display("t_live done");
  endtask
  task automatic t_irq;
    wchk(E0, 8'h20);
    pm.pulse(0);
    irq_is(1'b0);
    wchk(CTL, 8'h81);
    irq_is(1'b1);
    wchk(CTL, 8'h01);
    irq_is(1'b0);
    wchk(F0, 8'h00);
    wchk(E1, 8'h01);
    pm.pulse(6);
    wchk(CTL, 8'h81);
    irq_is(1'b0);
    wchk(CTL, 8'hC1);
    irq_is(1'b1);
    wchk(F1, 8'h00);
    irq_is(1'b0);
    pm.pulse(6);
    irq_is(1'b1);
    wchk(F1, 8'h00);
    irq_is(1'b0);
    wchk(E2, 8'h80);
    pm.pulse(7);
    irq_is(1'b1);
    wchk(F2, 8'h00);
    irq_is(1'b0);
    wchk(CTL, 8'h01);
    $display("t_irq done");
  endtask
  task automatic t_ext;
    wchk(SEL, 8'h03);
    pm.pins(8'h04);
    settle;
    rchk(F0, 8'h00);
    pm.pins(8'h0C);
    settle;
    rchk(F0, 8'h01);
    pm.pins(8'h04);
    settle;
    rchk(F0, 8'h01);
    wchk(CTL, 8'h81);
    irq_is(1'b0);
    wchk(E0, 8'h01);
    irq_is(1'b1);
    wchk(CTL, 8'h00);
    settle;
    wchk(F0, 8'h00);
    pm.pins(8'h0C);
    settle;
    rchk(F0, 8'h00);
    pm.pins(8'h04);
    settle;
    rchk(F0, 8'h01);
    $display("t_ext done");
  endtask
  initial begin
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_reset;
    t_regs;
    t_flags;
    t_live;
    t_irq;
    t_ext;
    end_of_test;
  end
endmodule // test_peripheral_irq_enable_flag_bank
`default_nettype wire
